/* hdl/acp_cfg.svh */
/*
 constants of the coprocessor host port: command fields, reset values, timing counts.
 assumes a single 125 MHz core clock; included by bare name.
*/
`ifndef ACP_CFG_SVH
`define ACP_CFG_SVH

// core clock period and read stall time
`define ACP_CLK_PERIOD_NS 8
`define ACP_RD_WAIT_NS    24
`define ACP_RD_WAIT_CYC   ((`ACP_RD_WAIT_NS + `ACP_CLK_PERIOD_NS - 1) / `ACP_CLK_PERIOD_NS)

// command byte fields
`define ACP_OP_LSB        0
`define ACP_OP_MSB        4
`define ACP_FMT_BIT       5
`define ACP_PREC_BIT      6
`define ACP_SVC_BIT       7

// reset values
`define ACP_CMD_RST       8'h00
`define ACP_STATUS_RST    8'h00
`define ACP_DATA_RST      8'h00
`define ACP_STROBE_RST    4'hE
`define ACP_PTR_RST       8'h00

`endif

/* hdl/acp_pkg.sv */
/*
 types of the coprocessor host port.
 assumes nothing beyond the tool's package support.
*/
package acp_pkg;

   // access sequencer states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_HOLD,
      ST_READ,
      ST_SERVE
   } acp_state_t;

   typedef logic [7:0] acp_byte_t;

endpackage

/* hdl/acp_sync.sv */
/*
 two-stage synchroniser for a group of asynchronous levels.
 assumes inputs are quasi-static levels; no multi-bit coherence is promised.
*/
`timescale 1ns/1ps
module acp_sync #(
   parameter int               WIDTH   = 4,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             nrst_in,
   // levels
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] stable_q;

   // the first stage feeds only the second stage
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clk_in or negedge nrst_in) begin
            if (!nrst_in) begin
               meta_q[i]   <= RST_VAL[i];
               stable_q[i] <= RST_VAL[i];
            end else begin
               meta_q[i]   <= async_in[i];
               stable_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   assign sync_out = stable_q;
endmodule // acp_sync

/* hdl/acp_stack.sv */
/*
 byte-wide operand stack, circular, no overflow detection.
 assumes push and pop never come in the same cycle.
*/
`timescale 1ns/1ps
`include "acp_cfg.svh"
module acp_stack #(
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   // stack access
   input  wire logic       push_in,
   input  wire logic       pop_in,
   input  wire logic [7:0] data_in,
   output logic      [7:0] top_out
);
   localparam int AW = $clog2(DEPTH);

   logic [7:0]    mem [DEPTH];
   logic [AW-1:0] ptr_q;
   logic [AW-1:0] ptr_d;
   logic [AW-1:0] top_idx;

   assign top_idx = ptr_q - AW'(1);
   assign top_out = mem[top_idx];
   assign ptr_d   = push_in ? ptr_q + AW'(1) : (pop_in ? top_idx : ptr_q);

   // pointer is control state; the byte array itself is never reset
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ptr_q <= AW'(`ACP_PTR_RST);
      end else begin
         ptr_q <= ptr_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (push_in) begin
         mem[ptr_q] <= data_in;
      end
   end
endmodule // acp_stack

/* hdl/acp_host_port.sv */
/*
 host bus port and execution handshake of a stack-based arithmetic coprocessor.
 assumes the arithmetic core outside starts on cmd_start_out, pulses exec_done_in once
 per command and offers its status byte on status_in in that cycle.
*/
// Behaviour
// RULE_01: one eight-bit two-way path carries operands, results, commands and status.
// RULE_02: data select low: write pushes bus byte, read pops stack byte.
// RULE_03: command select high: write latches command, read returns status byte.
// RULE_04: strobes count only while chip select is low.
// RULE_05: host never asserts read and write strobes together.
// RULE_06: data lines driven only while chip select and read are low.
// RULE_07: strobes are asynchronous to the core clock and are synchronised.
// RULE_08: reset aborts command, clears status, returns sequencer to idle.
// RULE_09: reset leaves operand stack contents alone.
// RULE_10: reset is held at least five clock periods.
// RULE_11: no power-up initialisation; state follows only the external reset.
// RULE_12: completion pulled low at finish, released by ack, reset or access.
// RULE_13: completion acknowledge low clears completion output.
// RULE_14: acknowledge tied low gives a one-cycle completion pulse.
// RULE_15: command bit 7 set raises service request at finish.
// RULE_16: service request holds until ack, reset or non-service command finishes.
// RULE_17: service acknowledge low clears service request.
// RULE_18: access during execution holds wait low until execution ends.
// RULE_19: valid read holds wait low for the stack access time.
// RULE_20: command bits 0 to 4 select the operation.
// RULE_21: command bit 5 selects fixed point when set, float when clear.
// RULE_22: command bit 6 selects 16-bit when set, 32-bit when clear.
// RULE_23: host keeps bit 6 clear for float; illegal combinations are undefined.
// RULE_24: each strobe passes two flip-flops before it acts; the raw chip select and read pins end the data drive after one flip-flop.
`timescale 1ns/1ps
`include "acp_cfg.svh"
module acp_host_port #(
   parameter int STACK_DEPTH = 16,
   parameter int RD_WAIT_CYC = `ACP_RD_WAIT_CYC
) (
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              nrst_in,
   // host bus control
   input  wire logic              cs_n_in,
   input  wire logic              cd_in,
   input  wire logic              rd_n_in,
   input  wire logic              wr_n_in,
   // host data lines
   input  wire acp_pkg::acp_byte_t host_data_lines_in,
   output acp_pkg::acp_byte_t     host_data_lines_out,
   output logic                   host_data_lines_oe_out,
   // completion and service handshake
   input  wire logic              completion_ack_n_in,
   input  wire logic              service_ack_n_in,
   output logic                   done_n_out,
   output logic                   done_oe_out,
   output logic                   service_request_out,
   output logic                   wait_n_out,
   // arithmetic core side
   input  wire logic              exec_done_in,
   input  wire acp_pkg::acp_byte_t status_in,
   output logic                   cmd_start_out,
   output logic [4:0]             cmd_op_out,
   output logic                   cmd_fixed_out,
   output logic                   cmd_single_out,
   output logic                   busy_out
);
   import acp_pkg::*;

   function automatic logic [4:0] cmd_op(input acp_byte_t c);
      cmd_op = c[`ACP_OP_MSB:`ACP_OP_LSB];
   endfunction

   // synchronised strobes
   logic [3:0] strobe_s;
   logic       cs_s;
   logic       rd_s;
   logic       wr_s;
   logic       cd_s;

   // sequencer and handshake state
   acp_state_t st_q;
   acp_state_t st_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic       acc_q;
   logic       exec_q;
   logic       exec_d;
   acp_byte_t  cmd_q;
   acp_byte_t  cmd_d;
   acp_byte_t  status_q;
   acp_byte_t  status_d;
   acp_byte_t  data_q;
   acp_byte_t  data_d;
   logic       oe_q;
   logic       oe_d;
   logic       done_q;
   logic       done_d;
   logic       service_request_q;
   logic       service_request_d;
   logic       wait_n_q;
   logic       wait_n_d;
   logic       start_q;

   // decode wires
   logic       rd_act;
   logic       wr_act;
   logic       acc_act;
   logic       acc_start;
   logic       go_access;
   logic       do_write;
   logic       go_read;
   logic       rd_done;
   logic       push;
   logic       pop;
   logic       cmd_load;
   logic       finish;
   logic       rd_pins;
   acp_byte_t  stack_top;

   acp_sync #(
      .WIDTH   (4),
      .RST_VAL (`ACP_STROBE_RST)
   ) u_sync (
      .clk_in   (clk_in),
      .nrst_in  (nrst_in),
      .async_in ({cs_n_in, rd_n_in, wr_n_in, cd_in}), // see RULE_07, see RULE_24
      .sync_out (strobe_s)
   );

   assign cs_s = strobe_s[3];
   assign rd_s = strobe_s[2];
   assign wr_s = strobe_s[1];
   assign cd_s = strobe_s[0];

   // strobes qualified by chip select; read and write are trusted exclusive
   assign rd_act    = !cs_s && !rd_s;                     // see RULE_04
   assign wr_act    = !cs_s && !wr_s;                     // see RULE_04, see RULE_05
   assign acc_act   = rd_act || wr_act;
   assign acc_start = acc_act && !acc_q;

   // an access that meets a running command parks in hold until it ends
   assign go_access = ((st_q == ST_IDLE) && acc_start && !exec_q)
                   || ((st_q == ST_HOLD) && acc_act && !exec_q); // see RULE_18
   assign do_write  = go_access && wr_act;
   assign go_read   = go_access && rd_act;
   assign rd_done   = (st_q == ST_READ) && (cnt_q == 4'h0);

   assign push      = do_write && !cd_s;                  // see RULE_02
   assign cmd_load  = do_write && cd_s;                   // see RULE_03
   assign pop       = rd_done && !cd_s;                   // see RULE_02
   assign finish    = exec_q && exec_done_in;

   // raw pins gate the driver so it lets go one edge after the strobe ends
   assign rd_pins   = !cs_n_in && !rd_n_in;

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      case (st_q)
         ST_IDLE: begin
            if (acc_start && exec_q) begin
               st_d = ST_HOLD;
            end else if (go_read) begin
               st_d  = ST_READ;
               cnt_d = 4'(RD_WAIT_CYC - 1);
            end else if (do_write) begin
               st_d = ST_SERVE;
            end
         end
         ST_HOLD: begin
            if (!acc_act) begin
               st_d = ST_IDLE;
            end else if (go_read) begin
               st_d  = ST_READ;
               cnt_d = 4'(RD_WAIT_CYC - 1);
            end else if (do_write) begin
               st_d = ST_SERVE;
            end
         end
         ST_READ: begin
            if (rd_done) begin
               st_d = ST_SERVE;
            end else begin
               cnt_d = cnt_q - 4'h1;                      // see RULE_19
            end
         end
         ST_SERVE: begin
            if (!acc_act) begin
               st_d = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   assign exec_d   = cmd_load || (exec_q && !exec_done_in);
   assign cmd_d    = cmd_load ? host_data_lines_in : cmd_q;    // see RULE_03
   assign status_d = finish ? status_in : status_q;
   assign data_d   = rd_done ? (cd_s ? status_q : stack_top) : data_q; // see RULE_02, see RULE_03
   assign oe_d     = (st_d == ST_SERVE) && rd_pins && (st_q != ST_IDLE)
                   && rd_act;                                  // see RULE_06, see RULE_01
   // set wins over every clear, so a tied-low ack still leaves a one-cycle pulse
   assign done_d   = finish || (done_q && completion_ack_n_in && !acc_start); // see RULE_12, see RULE_13, see RULE_14
   assign service_request_d  = finish ? cmd_q[`ACP_SVC_BIT] : (service_request_q && service_ack_n_in); // see RULE_15, see RULE_16, see RULE_17
   assign wait_n_d = !((st_d == ST_HOLD) || (st_d == ST_READ)); // see RULE_18, see RULE_19

   // reset clears control and status only; stack bytes survive
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q     <= ST_IDLE;                             // see RULE_08, see RULE_11
         cnt_q    <= 4'h0;
         acc_q    <= 1'b0;
         exec_q   <= 1'b0;                                // see RULE_08
         cmd_q    <= `ACP_CMD_RST;
         status_q <= `ACP_STATUS_RST;                     // see RULE_08
         data_q   <= `ACP_DATA_RST;
         oe_q     <= 1'b0;
         done_q   <= 1'b0;
         service_request_q  <= 1'b0;
         wait_n_q <= 1'b1;
         start_q  <= 1'b0;
      end else begin
         st_q     <= st_d;
         cnt_q    <= cnt_d;
         acc_q    <= acc_act;
         exec_q   <= exec_d;
         cmd_q    <= cmd_d;
         status_q <= status_d;
         data_q   <= data_d;
         oe_q     <= oe_d;
         done_q   <= done_d;
         service_request_q  <= service_request_d;
         wait_n_q <= wait_n_d;
         start_q  <= cmd_load;
      end
   end

   acp_stack #(
      .DEPTH (STACK_DEPTH)
   ) u_stack (
      .clk_in  (clk_in),
      .nrst_in (nrst_in),                                 // see RULE_09
      .push_in (push),
      .pop_in  (pop),
      .data_in (host_data_lines_in),
      .top_out (stack_top)
   );

   // open drain: only the enable moves, the level is always low
   assign done_n_out             = 1'b0;
   assign done_oe_out            = done_q;
   assign service_request_out    = service_request_q;
   assign wait_n_out             = wait_n_q;
   assign host_data_lines_out    = data_q;
   assign host_data_lines_oe_out = oe_q;
   assign cmd_start_out          = start_q;
   assign cmd_op_out             = cmd_op(cmd_q);              // see RULE_20
   assign cmd_fixed_out          = cmd_q[`ACP_FMT_BIT];        // see RULE_21
   // bit 6 passed raw; float commands with it set are the host's problem
   assign cmd_single_out         = cmd_q[`ACP_PREC_BIT];       // see RULE_22, see RULE_23
   assign busy_out               = exec_q;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   sequence s_read_go;
      (st_q == ST_IDLE || st_q == ST_HOLD) && go_read;
   endsequence

   sequence s_read_stall;
      !wait_n_out [*3];
   endsequence

   a_oe_read_only: assert property ( // see RULE_06
      host_data_lines_oe_out |-> $past(!cs_n_in && !rd_n_in))
      else $error("data lines driven outside a read");

   // pin seen high two edges back is what the synchronised select shows now
   a_cs_gates_strobe: assert property ( // see RULE_04
      $past(cs_n_in, 2) |-> !push && !cmd_load && !go_read)
      else $error("strobe acted without chip select");

   a_strobe_two_ff: assert property ( // see RULE_24
      acc_start |-> $past(!cs_n_in, 2) && !$past(acc_act))
      else $error("access started without two-stage sync");

   a_push_data: assert property ( // see RULE_02
      push |=> $past(!cd_s && wr_act) && !exec_q)
      else $error("push outside data write");

   a_cmd_fields: assert property ( // see RULE_03
      cmd_load |=> cmd_start_out && busy_out && cmd_op_out == $past(host_data_lines_in[4:0])
                   && cmd_fixed_out == $past(host_data_lines_in[5])
                   && cmd_single_out == $past(host_data_lines_in[6]))
      else $error("command byte not latched");

   a_read_stall: assert property ( // see RULE_19
      s_read_go |=> s_read_stall ##1 wait_n_out)
      else $error("read stall length wrong");

   a_busy_wait: assert property ( // see RULE_18
      (acc_start && exec_q && st_q == ST_IDLE) |=> !wait_n_out)
      else $error("no wait during execution");

   a_hold_wait: assert property ( // see RULE_18
      (st_q == ST_HOLD && exec_q && acc_act) |=> !wait_n_out && st_q == ST_HOLD)
      else $error("wait released while busy");

   a_end_set: assert property ( // see RULE_12
      finish |=> done_oe_out)
      else $error("completion not signalled");

   a_end_release: assert property ( // see RULE_12
      (acc_start && !finish) |=> !done_oe_out)
      else $error("completion not released by access");

   a_end_ack: assert property ( // see RULE_13
      (done_oe_out && !completion_ack_n_in && !finish) |=> !done_oe_out)
      else $error("completion ack ignored");

   a_svc_finish: assert property ( // see RULE_15
      finish |=> service_request_out == $past(cmd_q[7]))
      else $error("service request wrong at finish");

   a_svc_ack: assert property ( // see RULE_17
      (!service_ack_n_in && !finish) |=> !service_request_out)
      else $error("service ack ignored");

   a_svc_hold: assert property ( // see RULE_16
      (service_request_out && service_ack_n_in && !finish) |=> service_request_out)
      else $error("service request dropped early");

endmodule // acp_host_port

/* tb/acp_host_model.sv */
/*
 host cpu model for the coprocessor host port: drives chip select, command/data select and strobes.
 assumes the bench resolves the shared data lines and feeds the resolved byte back on bus_in.
*/
`timescale 1ns/1ps
module acp_host_model
   import acp_pkg::*;
(
   // clock
   input  wire logic      clk_in,
   // bus control toward the port
   output logic           cs_n_out,
   output logic           cd_out,
   output logic           rd_n_out,
   output logic           wr_n_out,
   // data lines
   output acp_byte_t      host_data_out,
   input  wire acp_byte_t bus_in,
   input  wire logic      dev_oe_in,
   input  wire logic      wait_n_in
);
   initial begin
      cs_n_out      = 1'b1;
      cd_out        = 1'b0;
      rd_n_out      = 1'b1;
      wr_n_out      = 1'b1;
      host_data_out = 8'hA5;
   end

   // one access per strobe low period; stall counts cycles with wait low
   task automatic access(input logic sel, input logic cdv, input logic rd, input acp_byte_t wd,
                         output acp_byte_t rdv, output int stall);
      int n;
      stall = 0;
      @(negedge clk_in);
      cs_n_out = ~sel;
      cd_out   = cdv;
      if (rd) begin
         // a released bus never shows the last byte again
         host_data_out = ~host_data_out;
         rd_n_out      = 1'b0;
      end else begin
         host_data_out = wd;
         wr_n_out      = 1'b0;
      end
      repeat (3) @(posedge clk_in);
      for (n = 0; n < 400; n++) begin
         @(negedge clk_in);
         if (wait_n_in === 1'b0) stall++;
         else if (!rd || dev_oe_in === 1'b1) break;
      end
      // a stuck handshake reads back as an impossible stall count
      if (n == 400) stall = -1;
      rdv           = bus_in;
      cs_n_out      = 1'b1;
      rd_n_out      = 1'b1;
      wr_n_out      = 1'b1;
      host_data_out = ~host_data_out;
      // strobes stay high long enough to be seen released
      repeat (3) @(posedge clk_in);
   endtask
endmodule // acp_host_model

/* tb/acp_host_port_bench.sv */
/*
 self-checking bench of the coprocessor host port: table of commands, then stack, select, busy and reset cases.
 assumes acp_host_model drives the bus and a small core model here answers each command.
*/
`timescale 1ns/1ps
module acp_host_port_bench;
   import acp_pkg::*;
   logic      clk_in = 1'b0, nrst_in = 1'b0, completion_ack_n_in = 1'b1, service_ack_n_in = 1'b1;
   logic      exec_done_in = 1'b0, cs_n, cd, rd_n, wr_n, oe, done_n, done_oe, service_request, wait_n;
   logic      cmd_start, fixed, single, busy;
   logic [4:0] op;
   acp_byte_t status_in = 8'h00, dout, hval, rv;
   wire acp_byte_t bus = (oe === 1'b1) ? dout : hval;
   int        fails = 0, n_compared = 0, core_delay = 4, core_cnt = 0, done_hi = 0, st, i;
   acp_byte_t row_cmd [6] = '{8'hEC, 8'h2C, 8'h90, 8'h01, 8'hF7, 8'h00};
   acp_byte_t row_st  [6] = '{8'h11, 8'h22, 8'h44, 8'h88, 8'hF0, 8'h0F};

   always #4 clk_in = ~clk_in;

   acp_host_port u_acp_host_port (.clk_in(clk_in), .nrst_in(nrst_in), .cs_n_in(cs_n), .cd_in(cd),
      .rd_n_in(rd_n), .wr_n_in(wr_n), .host_data_lines_in(bus), .host_data_lines_out(dout),
      .host_data_lines_oe_out(oe), .completion_ack_n_in(completion_ack_n_in),
      .service_ack_n_in(service_ack_n_in), .done_n_out(done_n), .done_oe_out(done_oe),
      .service_request_out(service_request), .wait_n_out(wait_n), .exec_done_in(exec_done_in),
      .status_in(status_in), .cmd_start_out(cmd_start), .cmd_op_out(op), .cmd_fixed_out(fixed),
      .cmd_single_out(single), .busy_out(busy));
   acp_host_model u_acp_host_model (.clk_in(clk_in), .cs_n_out(cs_n), .cd_out(cd), .rd_n_out(rd_n),
      .wr_n_out(wr_n), .host_data_out(hval), .bus_in(bus), .dev_oe_in(oe), .wait_n_in(wait_n));

   // core model: one finish pulse core_delay cycles after each start
   always @(negedge clk_in) begin
      exec_done_in = 1'b0;
      if (cmd_start === 1'b1) core_cnt = core_delay;
      else if (core_cnt > 0) begin
         core_cnt--;
         if (core_cnt == 0) exec_done_in = 1'b1;
      end
      if (done_oe === 1'b1) done_hi++;
   end

   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic do_reset();
      @(negedge clk_in);
      nrst_in = 1'b0;
      repeat (5) @(negedge clk_in);
      nrst_in = 1'b1;
   endtask

   // enter a command and wait until the core has finished it
   task automatic run_cmd(input acp_byte_t c);
      u_acp_host_model.access(1'b1, 1'b1, 1'b0, c, rv, st);
      for (int k = 0; k < 300 && busy !== 1'b0; k++) @(negedge clk_in);
      chk("cmd end", {7'h00, busy}, 8'h00);
   endtask

   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      #200000;
      fails++;
      results();
   end

   initial begin
      repeat (2) @(negedge clk_in);
      chk("rst oe", {7'h00, oe}, 8'h00);
      chk("rst done", {7'h00, done_oe}, 8'h00);
      chk("rst wait", {7'h00, wait_n}, 8'h01);
      chk("rst busy", {6'h00, busy, service_request}, 8'h00);
      repeat (4) @(negedge clk_in);
      nrst_in = 1'b1;
      $display("test reset done");
      for (i = 0; i < 6; i++) begin
         status_in = row_st[i];
         run_cmd(row_cmd[i]);
         chk("op", {3'h0, op}, {3'h0, row_cmd[i][4:0]});
         chk("fixed", {7'h00, fixed}, {7'h00, row_cmd[i][5]});
         chk("single", {7'h00, single}, {7'h00, row_cmd[i][6]});
         chk("service_request", {7'h00, service_request}, {7'h00, row_cmd[i][7]});
         chk("done", {7'h00, done_oe}, 8'h01);
         chk("done pin", {7'h00, done_n}, 8'h00);
         u_acp_host_model.access(1'b1, 1'b1, 1'b1, 8'h00, rv, st);
         chk("status", rv, row_st[i]);
         chk("status wait", st[7:0], 8'h03);
         chk("done cleared", {7'h00, done_oe}, 8'h00);
      end
      $display("test command table done");
      run_cmd(8'h80);
      chk("service_request set", {7'h00, service_request}, 8'h01);
      @(negedge clk_in);
      service_ack_n_in = 1'b0;
      @(negedge clk_in);
      service_ack_n_in = 1'b1;
      chk("service_ack_n", {7'h00, service_request}, 8'h00);
      run_cmd(8'h81);
      u_acp_host_model.access(1'b1, 1'b1, 1'b1, 8'h00, rv, st);
      chk("service_request held", {7'h00, service_request}, 8'h01);
      run_cmd(8'h01);
      chk("service_request later", {7'h00, service_request}, 8'h00);
      completion_ack_n_in = 1'b0;
      @(negedge clk_in);
      done_hi = 0;
      run_cmd(8'h02);
      repeat (10) @(negedge clk_in);
      chk("ack pulse", done_hi[7:0], 8'h01);
      completion_ack_n_in = 1'b1;
      run_cmd(8'h03);
      chk("ack set", {7'h00, done_oe}, 8'h01);
      completion_ack_n_in = 1'b0;
      @(negedge clk_in);
      chk("ack clears", {7'h00, done_oe}, 8'h00);
      completion_ack_n_in = 1'b1;
      $display("test handshake done");
      foreach (row_st[j]) u_acp_host_model.access(1'b1, 1'b0, 1'b0, row_st[j], rv, st);
      u_acp_host_model.access(1'b0, 1'b0, 1'b0, 8'h77, rv, st);
      for (i = 5; i >= 0; i--) begin
         u_acp_host_model.access(1'b1, 1'b0, 1'b1, 8'h00, rv, st);
         chk("pop", rv, row_st[i]);
         chk("pop wait", st[7:0], 8'h03);
         chk("released", {7'h00, oe}, 8'h00);
      end
      $display("test stack done");
      core_delay = 30;
      u_acp_host_model.access(1'b1, 1'b1, 1'b0, 8'h10, rv, st);
      u_acp_host_model.access(1'b1, 1'b0, 1'b0, 8'h3C, rv, st);
      chk("busy stall", {7'h00, st >= 15}, 8'h01);
      u_acp_host_model.access(1'b1, 1'b0, 1'b1, 8'h00, rv, st);
      chk("pop after busy", rv, 8'h3C);
      $display("test busy done");
      for (i = 0; i < 16; i++) u_acp_host_model.access(1'b1, 1'b0, 1'b0, 8'hE5, rv, st);
      core_delay = 200;
      u_acp_host_model.access(1'b1, 1'b1, 1'b0, 8'h81, rv, st);
      do_reset();
      @(negedge clk_in);
      chk("abort busy", {6'h00, busy, service_request}, 8'h00);
      chk("abort wait", {7'h00, wait_n}, 8'h01);
      u_acp_host_model.access(1'b1, 1'b0, 1'b1, 8'h00, rv, st);
      chk("stack kept", rv, 8'hE5);
      u_acp_host_model.access(1'b1, 1'b1, 1'b1, 8'h00, rv, st);
      chk("status cleared", rv, 8'h00);
      $display("test reset mid command done");
      results();
   end
endmodule // acp_host_port_bench
